/* File: rsq_array_model.sv */
// behavioural pixel array model feeding the sequencer
`timescale 1ns/10ps

module rsq_array_model (
  input  wire logic        clk_i,
  input  wire logic [10:0] row_i,
  input  wire logic        row_rd_i,
  input  wire logic [10:0] col_i,
  output logic      [9:0]  data_o
);
  logic [10:0] sel_row = 11'h000;

  // latch the selected row on each read pulse
  always_ff @(posedge clk_i) begin
    if (row_rd_i) sel_row <= row_i;
  end

  // pixel value encodes the low 5 bits of its own row and column address
  assign data_o = {sel_row[4:0], col_i[4:0]};
endmodule

/* File: rsq_monitor.sv */
// concurrent checks on the ports of the readout sequencer
`timescale 1ns/10ps

module rsq_monitor (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        arr_row_rd_o,
  input wire logic [9:0]  pix_data_i,
  input wire logic        pix_valid_o,
  input wire logic [9:0]  pix_data_o,
  input wire logic        emb_line_o,
  input wire logic        frame_start_o,
  input wire logic        line_start_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  a_bus_always_ok: assert property (hreadyout_o && !hresp_o)
    else $error("bus slave not ready or not okay");
  a_rdata_hold_idle: assert property (
    !(hsel_i && htrans_i[1] && hready_i && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data changed without a read");

  // ----------------------------------------------------------------
  // frame and line framing
  // ----------------------------------------------------------------
  a_frame_opens_line: assert property (frame_start_o |-> ##2 line_start_o)
    else $error("frame start without line start");
  a_line_start_gap: assert property (line_start_o |=> !line_start_o [*8])
    else $error("line starts too close");
  a_read_pulse_single: assert property (arr_row_rd_o |=> !arr_row_rd_o)
    else $error("row read pulse longer than one cycle");
  a_embed_is_valid: assert property (emb_line_o |-> pix_valid_o)
    else $error("embedded flag without valid");
  a_pixel_from_array: assert property (
    pix_valid_o && !emb_line_o |-> pix_data_o == $past(pix_data_i))
    else $error("pixel does not match array data");
  a_no_pixel_at_ls: assert property (pix_valid_o |-> !line_start_o)
    else $error("pixel on a line start cycle");

  // main scenarios
  c_frame: cover property (frame_start_o);
  c_embed: cover property (emb_line_o && pix_valid_o);
  c_read: cover property (hsel_i && htrans_i[1] && !hwrite_i);
endmodule

bind rsq_rolling_shutter_readout_sequencer rsq_monitor u_mon (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .arr_row_rd_o(arr_row_rd_o),
  .pix_data_i(pix_data_i), .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o),
  .emb_line_o(emb_line_o), .frame_start_o(frame_start_o), .line_start_o(line_start_o));

/* File: rsq_params.svh */
// constants of the rolling shutter readout sequencer: offsets, fields, resets, timing
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RSQ_OFF_CTRL        8'h00
`define RSQ_OFF_ORIENT      8'h04
`define RSQ_OFF_XSTART      8'h08
`define RSQ_OFF_YSTART      8'h0C
`define RSQ_OFF_XEND        8'h10
`define RSQ_OFF_YEND        8'h14
`define RSQ_OFF_XSIZE       8'h18
`define RSQ_OFF_YSIZE       8'h1C
`define RSQ_OFF_ODDINC      8'h20
`define RSQ_OFF_EXPOSURE    8'h24
`define RSQ_OFF_BAYER       8'h28
`define RSQ_OFF_STATUS      8'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSQ_CTRL_STREAM     0
`define RSQ_CTRL_EMBED      8
`define RSQ_ORIENT_HMIRROR  0
`define RSQ_ORIENT_VFLIP    1
`define RSQ_INC_X_LSB       0
`define RSQ_INC_Y_LSB       4
`define RSQ_STAT_STREAMING  0
`define RSQ_STAT_PRIMED     1
`define RSQ_STAT_FCNT_LSB   16

// ----------------------------------------------------------------
// reset values: 1600 x 1200 active image inside a 4 pixel border
// ----------------------------------------------------------------
`define RSQ_RST_XSTART      11'h004
`define RSQ_RST_YSTART      11'h004
`define RSQ_RST_XEND        11'h643
`define RSQ_RST_YEND        11'h4B3
`define RSQ_RST_XSIZE       11'h640
`define RSQ_RST_YSIZE       11'h4B0
`define RSQ_RST_ODDINC      3'h1
`define RSQ_RST_EXPOSURE    12'h100
`define RSQ_INC_SKIP        3'h3

// ----------------------------------------------------------------
// line and frame timing, in pixel clocks and lines
// ----------------------------------------------------------------
`define RSQ_EMB_LINES       12'h002
`define RSQ_LINE_BLANK      12'h2E1
`define RSQ_FRAME_BLANK     12'h093
`define RSQ_SLOT_RST_CUR    12'h000
`define RSQ_SLOT_RST_NXT    12'h001
`define RSQ_SLOT_READ       12'h002
`define RSQ_SLOT_PIX0       12'h004

`endif

/* File: rsq_pkg.sv */
// types of the rolling shutter readout sequencer
package rsq_pkg;

  typedef enum logic {
    RSQ_IDLE,
    RSQ_STREAM
  } rsq_mode_t;

  // colour of the first output pixel
  typedef enum logic [1:0] {
    RSQ_GRBG,
    RSQ_RGGB,
    RSQ_BGGR,
    RSQ_GBRG
  } rsq_order_t;

  // geometry and exposure in force for one frame
  typedef struct packed {
    logic [10:0] xs;
    logic [10:0] xe;
    logic [10:0] ys;
    logic [10:0] ye;
    logic [10:0] xo;
    logic [10:0] yo;
    logic        xskip;
    logic        yskip;
    logic        hm;
    logic        vf;
    logic        emb;
    logic [11:0] exp;
    logic [11:0] flen;
    logic [11:0] llen;
  } rsq_cfg_t;

  typedef struct packed {
    rsq_mode_t   mode;
    logic        dp_act;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic        stream_en;
    logic        emb_en;
    logic        hmir;
    logic        vflp;
    logic [10:0] xs;
    logic [10:0] xe;
    logic [10:0] ys;
    logic [10:0] ye;
    logic [10:0] xo;
    logic [10:0] yo;
    logic [2:0]  xinc;
    logic [2:0]  yinc;
    logic [11:0] exp;
    rsq_cfg_t    act;
    rsq_cfg_t    pend;
    logic [11:0] tmr;
    logic [11:0] line;
    logic        primed;
    logic [15:0] fcnt;
    logic [10:0] row;
    logic [10:0] col;
    logic        rst_p;
    logic        rd_p;
    logic        col_req;
    logic        emb_req;
    logic        valid;
    logic        emb_o;
    logic        fs;
    logic        ls;
    logic [9:0]  data;
    rsq_order_t  order;
  } rsq_state_t;

endpackage

/* File: rsq_rolling_shutter_readout_sequencer.sv */
// rolling shutter readout sequencer with its register slave
//
// Behaviour
// - while streaming, frames follow each other at a constant rate, rolling shutter
// - rows are stepped in turn: each row is reset, then read later
// - reset-to-read interval is exposure, identical for all rows of a frame
// - exposure changes never produce a frame with mixed row exposures
// - array addressing stays within the start and end address window
// - delivered width and height follow the output size registers
// - after reset the window gives a 1600 by 1200 image, no border
// - host may widen window by up to 4 border pixels; they are read
// - embedded enable set gives two embedded lines ahead of image lines
// - horizontal mirror reads each row from end column back to start
// - vertical flip reads rows from end row back to start row
// - bayer order register follows reversal bits, colour of first pixel
// - odd increment 1 or 3 per axis selects subsampling; host uses only those
// - subsampling shortens lines and frames, giving a higher frame rate; here line and frame length follow only output size registers and embedded enable
// - increment 3 reads two adjacent rows or columns, skips next two
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "rsq_params.svh"

module rsq_rolling_shutter_readout_sequencer (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [10:0] arr_row_o,
  output logic             arr_row_rst_o,
  output logic             arr_row_rd_o,
  output logic      [10:0] arr_col_o,
  input  wire logic [9:0]  pix_data_i,
  output logic             pix_valid_o,
  output logic      [9:0]  pix_data_o,
  output logic             emb_line_o,
  output logic             frame_start_o,
  output logic             line_start_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0]          rst_sync;
  logic                rst_n;
  rsq_pkg::rsq_state_t s;
  rsq_pkg::rsq_state_t next_s;

  // two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address of readout index i; msb flags a position inside the window
  function automatic logic [11:0] amap(input logic [10:0] st, input logic [10:0] en,
                                       input logic [11:0] i, input logic skip,
                                       input logic rev);
    logic [11:0] off;
    logic [10:0] a;
    off = skip ? {i[10:1], 1'b0, i[0]} : i;
    a   = rev ? en - off[10:0] : st + off[10:0];
    return {(!off[11] && off[10:0] <= en - st), a};
  endfunction

  function automatic logic [11:0] emb_n(input rsq_pkg::rsq_cfg_t c);
    return c.emb ? `RSQ_EMB_LINES : 12'h000;
  endfunction

  // snapshot of the programmed settings; exposure capped so every row gets its reset
  function automatic rsq_pkg::rsq_cfg_t cfg_load(input rsq_pkg::rsq_state_t r,
                                                input logic [11:0] cap);
    rsq_pkg::rsq_cfg_t c;
    c.xs    = r.xs;
    c.xe    = r.xe;
    c.ys    = r.ys;
    c.ye    = r.ye;
    c.xo    = r.xo;
    c.yo    = r.yo;
    c.xskip = (r.xinc == `RSQ_INC_SKIP);
    c.yskip = (r.yinc == `RSQ_INC_SKIP);
    c.hm    = r.hmir;
    c.vf    = r.vflp;
    c.emb   = r.emb_en;
    c.flen  = emb_n(c) + {1'b0, r.yo} + `RSQ_FRAME_BLANK;
    c.llen  = {1'b0, r.xo} + `RSQ_LINE_BLANK;
    c.exp   = r.exp;
    if (c.exp == 12'h000) begin
      c.exp = 12'h001;
    end
    if (c.exp > cap) begin
      c.exp = cap;
    end
    return c;
  endfunction

  // register read multiplexer
  function automatic logic [31:0] rd_mux(input rsq_pkg::rsq_state_t r, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `RSQ_OFF_CTRL: begin
        d[`RSQ_CTRL_STREAM] = r.stream_en;
        d[`RSQ_CTRL_EMBED]  = r.emb_en;
      end
      `RSQ_OFF_ORIENT: begin
        d[`RSQ_ORIENT_HMIRROR] = r.hmir;
        d[`RSQ_ORIENT_VFLIP]   = r.vflp;
      end
      `RSQ_OFF_XSTART:   d[10:0] = r.xs;
      `RSQ_OFF_YSTART:   d[10:0] = r.ys;
      `RSQ_OFF_XEND:     d[10:0] = r.xe;
      `RSQ_OFF_YEND:     d[10:0] = r.ye;
      `RSQ_OFF_XSIZE:    d[10:0] = r.xo;
      `RSQ_OFF_YSIZE:    d[10:0] = r.yo;
      `RSQ_OFF_ODDINC: begin
        d[`RSQ_INC_X_LSB +: 3] = r.xinc;
        d[`RSQ_INC_Y_LSB +: 3] = r.yinc;
      end
      `RSQ_OFF_EXPOSURE: d[11:0] = r.exp;
      `RSQ_OFF_BAYER:    d[1:0]  = r.order;
      `RSQ_OFF_STATUS: begin
        d[`RSQ_STAT_STREAMING]      = (r.mode == rsq_pkg::RSQ_STREAM);
        d[`RSQ_STAT_PRIMED]         = r.primed;
        d[`RSQ_STAT_FCNT_LSB +: 16] = r.fcnt;
      end
      default: d = 32'h0000_0000; // unmapped reads as zero
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic signed [13:0] idx;
  logic        [11:0] hit;
  logic        [11:0] row0;
  logic        [11:0] col0;
  rsq_pkg::rsq_cfg_t  c0;

  // bus slave, registers and readout sequencer
  always_comb begin
    next_s         = s;
    idx            = 14'sh0000;
    hit            = 12'h000;
    c0             = s.act;
    next_s.rst_p   = 1'b0;
    next_s.rd_p    = 1'b0;
    next_s.col_req = 1'b0;
    next_s.emb_req = 1'b0;
    next_s.fs      = 1'b0;
    next_s.ls      = 1'b0;

    // address phase: capture, prepare read data for the data phase
    if (hready_i) begin
      next_s.dp_act = hsel_i && htrans_i[1];
      next_s.dp_wr  = hwrite_i;
      next_s.dp_addr = haddr_i[7:0];
      if (hsel_i && htrans_i[1] && !hwrite_i) begin
        next_s.rdata = rd_mux(s, haddr_i[7:0]);
      end
    end

    // data phase write
    if (s.dp_act && s.dp_wr) begin
      case (s.dp_addr)
        `RSQ_OFF_CTRL: begin
          next_s.stream_en = hwdata_i[`RSQ_CTRL_STREAM];
          next_s.emb_en    = hwdata_i[`RSQ_CTRL_EMBED];
        end
        `RSQ_OFF_ORIENT: begin
          next_s.hmir = hwdata_i[`RSQ_ORIENT_HMIRROR];
          next_s.vflp = hwdata_i[`RSQ_ORIENT_VFLIP];
        end
        `RSQ_OFF_XSTART:   next_s.xs = hwdata_i[10:0];
        `RSQ_OFF_YSTART:   next_s.ys = hwdata_i[10:0];
        `RSQ_OFF_XEND:     next_s.xe = hwdata_i[10:0];
        `RSQ_OFF_YEND:     next_s.ye = hwdata_i[10:0];
        `RSQ_OFF_XSIZE:    next_s.xo = hwdata_i[10:0];
        `RSQ_OFF_YSIZE:    next_s.yo = hwdata_i[10:0];
        `RSQ_OFF_ODDINC: begin
          next_s.xinc = hwdata_i[`RSQ_INC_X_LSB +: 3];
          next_s.yinc = hwdata_i[`RSQ_INC_Y_LSB +: 3];
        end
        `RSQ_OFF_EXPOSURE: next_s.exp = hwdata_i[11:0];
        default: ; // read-only and unmapped writes ignored
      endcase
    end

    // bayer order of the first pixel from programmed window and reversal
    row0 = amap(s.ys, s.ye, 12'h000, 1'b0, s.vflp);
    col0 = amap(s.xs, s.xe, 12'h000, 1'b0, s.hmir);
    next_s.order = rsq_pkg::rsq_order_t'({row0[0], col0[0]});

    // pixel pipeline: array data is taken in the same cycle as its column address
    next_s.valid = (s.col_req || s.emb_req) && s.primed;
    next_s.emb_o = s.emb_req && s.primed; // no embedded flag on the unprimed frame
    if (s.col_req) begin
      next_s.data = pix_data_i;
    end else if (s.emb_req) begin
      next_s.data = (s.col == 11'h000) ? s.fcnt[9:0] :
                    (s.col == 11'h001) ? s.act.exp[9:0] : 10'h000;
    end

    unique case (s.mode)
      rsq_pkg::RSQ_IDLE: begin
        if (s.stream_en) begin
          c0 = cfg_load(s, 12'hFFF);
          next_s.act    = cfg_load(s, c0.flen);
          next_s.pend   = cfg_load(s, c0.flen);
          next_s.tmr    = 12'h000;
          next_s.line   = 12'h000;
          next_s.primed = 1'b0;
          next_s.mode   = rsq_pkg::RSQ_STREAM;
        end
      end
      rsq_pkg::RSQ_STREAM: begin
        // line and frame timebase, fixed for the frame
        if (s.tmr == s.act.llen - 12'h001) begin
          next_s.tmr = 12'h000;
          if (s.line == s.act.flen - 12'h001) begin
            next_s.line   = 12'h000;
            next_s.act    = s.pend;
            next_s.pend   = cfg_load(s, s.pend.flen);
            next_s.fcnt   = s.fcnt + 16'h0001;
            next_s.primed = 1'b1; // first frame had partial exposure
            if (!s.stream_en) begin
              next_s.mode = rsq_pkg::RSQ_IDLE;
            end
          end else begin
            next_s.line = s.line + 12'h001;
          end
        end else begin
          next_s.tmr = s.tmr + 12'h001;
        end

        if (s.line == 12'h000 && s.tmr == 12'h000) begin
          next_s.fs = s.primed;
        end

        // reset of a row of this frame, exposure lines ahead of its read
        if (s.tmr == `RSQ_SLOT_RST_CUR) begin
          idx = $signed({2'b00, s.line}) + $signed({2'b00, s.act.exp})
                - $signed({2'b00, emb_n(s.act)});
          if (idx >= 14'sh0000 && idx < $signed({3'b000, s.act.yo})) begin
            hit = amap(s.act.ys, s.act.ye, idx[11:0], s.act.yskip, s.act.vf);
            next_s.row   = hit[10:0];
            next_s.rst_p = hit[11];
          end
        end

        // reset of a row of the next frame, under the next frame's settings
        if (s.tmr == `RSQ_SLOT_RST_NXT) begin
          idx = $signed({2'b00, s.line}) + $signed({2'b00, s.pend.exp})
                - $signed({2'b00, emb_n(s.pend)}) - $signed({2'b00, s.act.flen});
          if (idx >= 14'sh0000 && idx < $signed({3'b000, s.pend.yo})) begin
            hit = amap(s.pend.ys, s.pend.ye, idx[11:0], s.pend.yskip, s.pend.vf);
            next_s.row   = hit[10:0];
            next_s.rst_p = hit[11];
          end
        end

        // row read, after embedded lines
        if (s.tmr == `RSQ_SLOT_READ && s.line >= emb_n(s.act)
            && s.line - emb_n(s.act) < {1'b0, s.act.yo}) begin
          hit = amap(s.act.ys, s.act.ye, s.line - emb_n(s.act), s.act.yskip, s.act.vf);
          next_s.row  = hit[10:0];
          next_s.rd_p = hit[11];
          next_s.ls   = s.primed;
        end else if (s.tmr == `RSQ_SLOT_READ && s.line < emb_n(s.act)) begin
          next_s.ls = s.primed;
        end

        // column stepping over the output width
        if (s.tmr >= `RSQ_SLOT_PIX0 && s.tmr - `RSQ_SLOT_PIX0 < {1'b0, s.act.xo}) begin
          if (s.line < emb_n(s.act)) begin
            next_s.col     = 11'(s.tmr - `RSQ_SLOT_PIX0);
            next_s.emb_req = 1'b1;
          end else if (s.line - emb_n(s.act) < {1'b0, s.act.yo}) begin
            hit = amap(s.act.xs, s.act.xe, s.tmr - `RSQ_SLOT_PIX0, s.act.xskip, s.act.hm);
            next_s.col     = hit[10:0];
            next_s.col_req = hit[11];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // all state, reset to the default full-resolution window
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s           <= '0;
      s.mode      <= rsq_pkg::RSQ_IDLE;
      s.xs        <= `RSQ_RST_XSTART;
      s.ys        <= `RSQ_RST_YSTART;
      s.xe        <= `RSQ_RST_XEND;
      s.ye        <= `RSQ_RST_YEND;
      s.xo        <= `RSQ_RST_XSIZE;
      s.yo        <= `RSQ_RST_YSIZE;
      s.xinc      <= `RSQ_RST_ODDINC;
      s.yinc      <= `RSQ_RST_ODDINC;
      s.exp       <= `RSQ_RST_EXPOSURE;
      s.order     <= rsq_pkg::RSQ_GRBG;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave, always okay
  assign hreadyout_o   = 1'b1;
  assign hresp_o       = 1'b0;
  assign hrdata_o      = s.rdata;
  assign arr_row_o     = s.row;
  assign arr_row_rst_o = s.rst_p;
  assign arr_row_rd_o  = s.rd_p;
  assign arr_col_o     = s.col;
  assign pix_valid_o   = s.valid;
  assign pix_data_o    = s.data;
  assign emb_line_o    = s.emb_o;
  assign frame_start_o = s.fs;
  assign line_start_o  = s.ls;

endmodule

/* File: tb_top.sv */
// self-checking bench for the rolling shutter readout sequencer
`timescale 1ns/10ps
`include "rsq_params.svh"

module tb_top;
  logic        ref_clk_i;
  logic        resetn_i = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [10:0] arr_row;
  logic        row_rst;
  logic        row_rd;
  logic [10:0] arr_col;
  logic [9:0]  pix_in;
  logic        pix_valid;
  logic [9:0]  pix_data;
  logic        emb_line;
  logic        fs;
  logic        ls;
  logic [31:0] rd;
  int          err_count = 0;
  int          checks = 0;
  // reset table: offset and value, last entry unmapped
  logic [7:0]  rst_a [12] = '{`RSQ_OFF_CTRL, `RSQ_OFF_ORIENT, `RSQ_OFF_XSTART,
    `RSQ_OFF_YSTART, `RSQ_OFF_XEND, `RSQ_OFF_YEND, `RSQ_OFF_XSIZE, `RSQ_OFF_YSIZE,
    `RSQ_OFF_ODDINC, `RSQ_OFF_EXPOSURE, `RSQ_OFF_BAYER, 8'h30};
  logic [31:0] rst_v [12] = '{32'h0, 32'h0, 32'h4, 32'h4, 32'h643, 32'h4B3, 32'h640,
    32'h4B0, 32'h11, 32'h100, 32'h0, 32'h0};
  // stream setup: border window 0..7 x 0..3, x skip, both reversals, embedded data
  logic [7:0]  cfg_a [10] = '{`RSQ_OFF_XSTART, `RSQ_OFF_XEND, `RSQ_OFF_XSIZE,
    `RSQ_OFF_YSTART, `RSQ_OFF_YEND, `RSQ_OFF_YSIZE, `RSQ_OFF_ODDINC,
    `RSQ_OFF_EXPOSURE, `RSQ_OFF_ORIENT, `RSQ_OFF_CTRL};
  logic [31:0] cfg_v [10] = '{32'h0, 32'h7, 32'h4, 32'h0, 32'h3, 32'h4, 32'h13,
    32'h2, 32'h3, 32'h101};

  rsq_rolling_shutter_readout_sequencer dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .arr_row_o(arr_row), .arr_row_rst_o(row_rst), .arr_row_rd_o(row_rd),
    .arr_col_o(arr_col), .pix_data_i(pix_in), .pix_valid_o(pix_valid),
    .pix_data_o(pix_data), .emb_line_o(emb_line), .frame_start_o(fs),
    .line_start_o(ls));

  rsq_array_model u_array (
    .clk_i(ref_clk_i), .row_i(arr_row), .row_rd_i(row_rd), .col_i(arr_col),
    .data_o(pix_in));

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // one suppressed frame of about 113k cycles, six lines of capture, setup
  initial begin
    repeat (125000) @(posedge ref_clk_i);
    err_count++;
    $display("watchdog expired at %0t", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single word write: address phase, then data phase
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
  endtask

  // single word read: data taken at the end of the data phase
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // capture one output frame and compare every image pixel and the embedded exposure word
  task automatic cap_frame;
    int n;
    int e;
    int t;
    int tls;
    int tl2;
    int trst;
    int trd;
    logic [10:0] r;
    logic [10:0] c;
    n = 0;
    e = 0;
    tls = 0;
    tl2 = 0;
    trst = 0;
    trd = 0;
    do @(negedge ref_clk_i); while (fs !== 1'b1);
    for (t = 1; n < 16; t++) begin
      @(negedge ref_clk_i);
      if (ls === 1'b1 && tls == 0) tls = t;
      else if (ls === 1'b1 && tl2 == 0) tl2 = t;
      if (row_rst === 1'b1 && arr_row === 11'h000) trst = t;
      if (row_rd === 1'b1 && arr_row === 11'h000) trd = t;
      if (pix_valid === 1'b1 && emb_line === 1'b1) begin
        if (e == 1) chk({22'h0, pix_data}, 32'h2);
        e++;
      end else if (pix_valid === 1'b1) begin
        if (n == 0) chk(32'(e), 32'h8);
        r = 11'(3 - n / 4);
        c = 11'(7 - (4 * ((n % 4) / 2) + n % 2));
        chk({22'h0, pix_data}, {22'h0, r[4:0], c[4:0]});
        n++;
      end
    end
    chk(32'(tl2 - tls), 32'(`RSQ_LINE_BLANK) + 32'h4);
    chk(32'(trd - trst), 32'h2 * (32'(`RSQ_LINE_BLANK) + 32'h4) + 32'(`RSQ_SLOT_READ));
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 12; i++) begin
      bus_rd(rst_a[i], rd);
      chk(rd, rst_v[i]);
    end
    $display("test reset values done");
    for (int o = 0; o < 4; o++) begin
      bus_wr(`RSQ_OFF_ORIENT, 32'(o));
      bus_rd(`RSQ_OFF_BAYER, rd);
      chk(rd, 32'(o));
    end
    bus_wr(`RSQ_OFF_BAYER, 32'h0);
    bus_rd(`RSQ_OFF_BAYER, rd);
    chk(rd, 32'h3);
    bus_wr(8'h30, 32'hFFFF);
    bus_rd(8'h30, rd);
    chk(rd, 32'h0);
    $display("test orientation order done");
    for (int i = 0; i < 10; i++) bus_wr(cfg_a[i], cfg_v[i]);
    cap_frame();
    bus_rd(`RSQ_OFF_STATUS, rd);
    chk(rd & 32'h3, 32'h3);
    $display("test streaming frame done");
    finish_test();
  end
endmodule
